// [design/msp_device.sv]
// Sensor end of the serial port, with its motion indication pin.
// Assumes pins come from another clock domain; rd_data_i is valid
// in the cycle after rd_req_o.
`timescale 1ns/100ps
module msp_device (
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               ce_i,
    msp_if.dev                      bus,
    input  wire logic               motion_event_i,
    input  wire msp_pkg::msp_byte_t rd_data_i,
    output logic                    rd_req_o,
    output msp_pkg::msp_addr_t      rd_addr_o,
    output logic                    wr_valid_o,
    output msp_pkg::msp_addr_t      wr_addr_o,
    output msp_pkg::msp_byte_t      wr_data_o
);
    import msp_pkg::*;

    // ==========================================================
    // Pin synchronisers {cs_n, mosi, sclk}
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic       sclk_d;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sy1    <= 3'h5;
            sy2    <= 3'h5;
            sclk_d <= 1'b1;
        end else if (ce_i) begin
            sy1    <= {bus.cs_n, bus.mosi, bus.sclk};
            sy2    <= sy1;
            sclk_d <= sy2[0];
        end
    end
    wire cs_n_s = sy2[2];
    wire mosi_s = sy2[1];
    wire rise   = sy2[0] & ~sclk_d;
    wire fall   = ~sy2[0] & sclk_d;

    // ==========================================================
    // Port state machine
    msp_dev_state_e state, next_state;
    logic [2:0]     cnt, next_cnt, bidx, next_bidx;
    msp_byte_t      shreg, next_shreg, tx, next_tx, rx_byte;
    logic           burst, next_burst, load, next_load;
    logic           miso, next_miso, miso_oe_n, next_miso_oe_n;
    logic           next_rd_req, next_wr_valid;
    msp_addr_t      next_rd_addr, next_wr_addr;
    msp_byte_t      next_wr_data;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_bidx      = bidx;
        next_shreg     = shreg;
        next_tx        = load ? rd_data_i : tx;
        next_burst     = burst;
        next_load      = rd_req_o;
        next_miso      = miso;
        next_miso_oe_n = miso_oe_n;
        next_rd_req    = 1'b0;
        next_rd_addr   = rd_addr_o;
        next_wr_valid  = 1'b0;
        next_wr_addr   = wr_addr_o;
        next_wr_data   = wr_data_o;
        rx_byte        = {shreg[6:0], mosi_s};
        if (cs_n_s) begin
            // Rising select aborts anything, including a burst
            next_state     = D_IDLE;
            next_cnt       = 3'h0;
            next_burst     = 1'b0;
            next_miso_oe_n = 1'b1;
        end else begin
            case (state)
                D_IDLE: begin
                    next_state = D_ADDR;
                    next_cnt   = 3'h0;
                end
                D_ADDR, D_WDATA: begin
                    if (rise) begin
                        next_shreg = rx_byte;
                        next_cnt   = cnt + 3'h1;
                        if (cnt == 3'h7 && state == D_WDATA) begin
                            next_wr_valid = 1'b1;
                            next_wr_data  = rx_byte;
                            next_state    = D_ADDR;
                        end else if (cnt == 3'h7 && rx_byte[DIR_BIT]) begin
                            next_wr_addr = rx_byte[6:0];
                            next_state   = D_WDATA;
                        end else if (cnt == 3'h7) begin
                            next_burst   = (rx_byte[6:0] == BURST_ADDR);
                            next_bidx    = 3'h0;
                            next_rd_req  = 1'b1;
                            next_rd_addr = (rx_byte[6:0] == BURST_ADDR) ? MOTION_ADDR
                                                                        : rx_byte[6:0];
                            next_state   = D_RDATA;
                        end
                    end
                end
                D_RDATA: begin
                    next_miso_oe_n = 1'b0;
                    if (fall) begin
                        next_miso = tx[7];
                        next_tx   = {tx[6:0], 1'b0};
                    end else if (rise) begin
                        next_cnt = cnt + 3'h1;
                        if (cnt == 3'h7 && !burst) begin
                            next_state = D_ADDR;
                        end else if (cnt == 3'h7 && bidx == BURST_LAST) begin
                            next_state = D_LOCK;
                        end else if (cnt == 3'h7) begin
                            next_bidx    = bidx + 3'h1;
                            next_rd_req  = 1'b1;
                            next_rd_addr = rd_addr_o + 7'h01;
                        end
                    end
                end
                D_LOCK: next_state = D_LOCK;
                default: next_state = D_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state      <= D_IDLE;
            cnt        <= 3'h0;
            bidx       <= 3'h0;
            shreg      <= 8'h00;
            tx         <= 8'h00;
            burst      <= 1'b0;
            load       <= 1'b0;
            miso       <= 1'b1;
            miso_oe_n  <= 1'b1;
            rd_req_o   <= 1'b0;
            rd_addr_o  <= 7'h00;
            wr_valid_o <= 1'b0;
            wr_addr_o  <= 7'h00;
            wr_data_o  <= 8'h00;
        end else if (ce_i) begin
            state      <= next_state;
            cnt        <= next_cnt;
            bidx       <= next_bidx;
            shreg      <= next_shreg;
            tx         <= next_tx;
            burst      <= next_burst;
            load       <= next_load;
            miso       <= next_miso;
            miso_oe_n  <= next_miso_oe_n;
            rd_req_o   <= next_rd_req;
            rd_addr_o  <= next_rd_addr;
            wr_valid_o <= next_wr_valid;
            wr_addr_o  <= next_wr_addr;
            wr_data_o  <= next_wr_data;
        end
    end

    // ==========================================================
    // Motion status and pin
    logic motion, next_motion, seen_x, next_seen_x, seen_y, next_seen_y;
    logic motion_n, clr;

    always_comb begin
        clr = (wr_valid_o && wr_addr_o == MOTION_ADDR) || (seen_x && seen_y);
        // A new event in the clearing cycle keeps the bit set
        next_motion = motion_event_i | (motion & ~clr);
        next_seen_x = motion & ~clr & (seen_x | (rd_req_o && rd_addr_o == DELTA_X_ADDR));
        next_seen_y = motion & ~clr & (seen_y | (rd_req_o && rd_addr_o == DELTA_Y_ADDR));
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            motion   <= 1'b0;
            seen_x   <= 1'b0;
            seen_y   <= 1'b0;
            motion_n <= 1'b1;
        end else if (ce_i) begin
            motion   <= next_motion;
            seen_x   <= next_seen_x;
            seen_y   <= next_seen_y;
            motion_n <= ~next_motion;
        end
    end

    assign bus.miso      = miso;
    assign bus.miso_oe_n = miso_oe_n;
    assign bus.motion_n  = motion_n;
endmodule : msp_device

// [design/msp_host.sv]
// Host controller end of the sensor serial port.
// Assumes a pulled-up MISO line and a sensor clocked independently.
// Function
// - Motion pin low while motion bit set
// - Motion pin high once bit cleared
// - Only the master starts transfers
// - Select high: ignore inputs, release MISO
// - Port enabled only after select falls
// - Select rising aborts and resets port
// - Gaps still apply after an abort
// - Frame each transaction with select
// - Raise select to end burst mode
// - Write: direction one, address, data byte
// - Device samples MOSI on rising edges
// - Read: direction zero address, MISO data
// - Device shifts MISO on falling edges
// - MISO held to next fall; clock high half period
// - Keep write-to-write gap
// - Keep write-to-read gap
// - Wait address-to-data delay in reads
// - Keep read-to-next gap
// - Write-to-write gap is 30 us
// - Write-to-read gap is 20 us
// - Read-to-next gap is 500 ns
// - Address-to-data delay is 4 us
`timescale 1ns/100ps
module msp_host #(
    parameter int SCLK_HALF = msp_pkg::SCLK_HALF_DEFAULT
) (
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               ce_i,
    msp_if.host                     bus,
    input  wire logic               cmd_valid_i,
    output logic                    cmd_ready_o,
    input  wire logic               cmd_write_i,
    input  wire msp_pkg::msp_addr_t cmd_addr_i,
    input  wire msp_pkg::msp_byte_t cmd_data_i,
    input  wire logic [2:0]         cmd_extra_i,
    output logic                    rsp_valid_o,
    output msp_pkg::msp_byte_t      rsp_data_o,
    output logic                    motion_o
);
    import msp_pkg::*;

    localparam msp_tmr_t HALF_CYC = msp_tmr_t'(SCLK_HALF);

    // ==========================================================
    // Synchronisers for MISO and the motion pin
    logic miso_m;
    logic miso_s;
    logic mot_m;
    logic mot_s;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            miso_m <= 1'b1;
            miso_s <= 1'b1;
            mot_m  <= 1'b1;
            mot_s  <= 1'b1;
        end else if (ce_i) begin
            miso_m <= bus.miso_line;
            miso_s <= miso_m;
            mot_m  <= bus.motion_n;
            mot_s  <= mot_m;
        end
    end

    // ==========================================================
    // Transaction sequencer
    msp_host_state_e state, next_state;
    msp_tmr_t        gap, next_gap, tmr, next_tmr, need;
    logic            sclk, next_sclk;
    logic            mosi, next_mosi;
    logic            cs_n, next_cs_n;
    logic            is_wr, next_is_wr;
    logic            last_wr, next_last_wr;
    logic            in_data, next_in_data;
    logic [2:0]      left, next_left;
    logic [3:0]      cnt, next_cnt;
    msp_addr_t       addr, next_addr;
    msp_byte_t       wdata, next_wdata;
    msp_byte_t       sh, next_sh;
    msp_byte_t       rx, next_rx, smp;
    logic            next_ready;
    logic            next_rsp_valid;
    msp_byte_t       next_rsp_data;
    logic            tick;

    always_comb begin
        next_state     = state;
        next_gap       = (gap == '1) ? gap : gap + 1'b1;
        next_tmr       = (tmr == '0) ? tmr : tmr - 1'b1;
        next_sclk      = sclk;
        next_mosi      = mosi;
        next_cs_n      = cs_n;
        next_is_wr     = is_wr;
        next_last_wr   = last_wr;
        next_in_data   = in_data;
        next_left      = left;
        next_cnt       = cnt;
        next_addr      = addr;
        next_wdata     = wdata;
        next_sh        = sh;
        next_rx        = rx;
        next_ready     = cmd_ready_o;
        next_rsp_valid = 1'b0;
        next_rsp_data  = rsp_data_o;
        tick           = (tmr == '0);
        smp            = {rx[6:0], miso_s};
        // Gap counted from the last rising clock edge of the previous command
        if (last_wr) begin
            need = is_wr ? WW_CYC : WR_CYC;
        end else begin
            need = is_wr ? RW_CYC : RR_CYC;
        end
        case (state)
            H_IDLE: begin
                if (cmd_ready_o && cmd_valid_i) begin
                    next_ready = 1'b0;
                    next_is_wr = cmd_write_i;
                    next_addr  = cmd_addr_i;
                    next_wdata = cmd_data_i;
                    next_left  = cmd_write_i ? 3'h0 : cmd_extra_i;
                    next_state = H_GAP;
                end
            end
            H_GAP: begin
                // Gaps hold after an aborted command too
                if (gap >= need) begin
                    next_cs_n  = 1'b0;
                    next_tmr   = CSS_CYC - 1'b1;
                    next_state = H_SETUP;
                end
            end
            H_SETUP: begin
                if (tick) begin
                    next_sh      = {is_wr, addr};
                    next_cnt     = 4'h0;
                    next_in_data = 1'b0;
                    next_tmr     = '0;
                    next_state   = H_SHIFT;
                end
            end
            H_RAD: begin
                if (tick) begin
                    next_tmr   = '0;
                    next_state = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    next_tmr = HALF_CYC - 1'b1;
                    if (!sclk) begin
                        next_sclk = 1'b1;
                        next_cnt  = cnt + 4'h1;
                        next_gap  = '0;
                    end else begin
                        // MISO is read just before the next fall, where it is held
                        if (cnt != 4'h0 && in_data && !is_wr) begin
                            next_rx = smp;
                        end
                        if (cnt != 4'h8) begin
                            next_sclk = 1'b0;
                            next_mosi = sh[7];
                            next_sh   = {sh[6:0], 1'b0};
                        end else if (!in_data) begin
                            next_in_data = 1'b1;
                            next_cnt     = 4'h0;
                            next_sh      = wdata;
                            if (!is_wr) begin
                                next_tmr   = RAD_CYC - 1'b1;
                                next_state = H_RAD;
                            end
                        end else begin
                            if (!is_wr) begin
                                next_rsp_valid = 1'b1;
                                next_rsp_data  = smp;
                            end
                            if (left != 3'h0) begin
                                // Next burst byte follows at the normal rate, no extra high phase
                                next_left = left - 3'h1;
                                next_cnt  = 4'h0;
                                next_sclk = 1'b0;
                                next_mosi = sh[7];
                                next_sh   = {sh[6:0], 1'b0};
                            end else begin
                                // Raising select also ends any burst
                                next_cs_n    = 1'b1;
                                next_last_wr = is_wr;
                                next_ready   = 1'b1;
                                next_state   = H_IDLE;
                            end
                        end
                    end
                end
            end
            default: begin
                next_state = H_IDLE;
                next_cs_n  = 1'b1;
                next_sclk  = 1'b1;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state       <= H_IDLE;
            gap         <= '1;
            tmr         <= '0;
            sclk        <= 1'b1;
            mosi        <= 1'b1;
            cs_n        <= 1'b1;
            is_wr       <= 1'b0;
            last_wr     <= 1'b0;
            in_data     <= 1'b0;
            left        <= 3'h0;
            cnt         <= 4'h0;
            addr        <= 7'h00;
            wdata       <= 8'h00;
            sh          <= 8'h00;
            rx          <= 8'h00;
            cmd_ready_o <= 1'b1;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 8'h00;
            motion_o    <= 1'b0;
        end else if (ce_i) begin
            state       <= next_state;
            gap         <= next_gap;
            tmr         <= next_tmr;
            sclk        <= next_sclk;
            mosi        <= next_mosi;
            cs_n        <= next_cs_n;
            is_wr       <= next_is_wr;
            last_wr     <= next_last_wr;
            in_data     <= next_in_data;
            left        <= next_left;
            cnt         <= next_cnt;
            addr        <= next_addr;
            wdata       <= next_wdata;
            sh          <= next_sh;
            rx          <= next_rx;
            cmd_ready_o <= next_ready;
            rsp_valid_o <= next_rsp_valid;
            rsp_data_o  <= next_rsp_data;
            motion_o    <= ~mot_s;
        end
    end

    assign bus.sclk = sclk;
    assign bus.mosi = mosi;
    assign bus.cs_n = cs_n;
endmodule : msp_host

// [design/msp_if.sv]
// Pins between the sensor serial port and its host controller.
// MISO is resolved here with a pull-up while the device does not drive.
`timescale 1ns/100ps
interface msp_if;
    logic sclk;
    logic mosi;
    logic cs_n;
    logic miso;
    logic miso_oe_n;
    logic motion_n;
    logic miso_line;

    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport dev  (input sclk, input mosi, input cs_n,
                  output miso, output miso_oe_n, output motion_n);
    modport host (output sclk, output mosi, output cs_n,
                  input miso_line, input motion_n);
endinterface : msp_if

// [design/msp_pkg.sv]
// Constants, types and states shared by both serial port ends.
// Assumes both ends run from a 10 MHz system clock.
package msp_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS         = 100;
    localparam int WRITE_WRITE_GAP_NS    = 30000;
    localparam int WRITE_READ_GAP_NS     = 20000;
    localparam int READ_READ_GAP_NS      = 500;
    localparam int READ_WRITE_GAP_NS     = 500;
    localparam int ADDRESS_DATA_DELAY_NS = 4000;
    localparam int CS_SETUP_NS           = 120;
    localparam int SCLK_HALF_DEFAULT     = 4;
    localparam int TMR_W                 = 16;

    typedef logic [TMR_W-1:0] msp_tmr_t;

    // Least times round up to whole cycles
    localparam msp_tmr_t WW_CYC  = msp_tmr_t'((WRITE_WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam msp_tmr_t WR_CYC  = msp_tmr_t'((WRITE_READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam msp_tmr_t RR_CYC  = msp_tmr_t'((READ_READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam msp_tmr_t RW_CYC  = msp_tmr_t'((READ_WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam msp_tmr_t RAD_CYC = msp_tmr_t'((ADDRESS_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam msp_tmr_t CSS_CYC = msp_tmr_t'((CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Frame layout and addresses
    typedef logic [6:0] msp_addr_t;
    typedef logic [7:0] msp_byte_t;
    localparam int        DIR_BIT      = 7;
    localparam msp_addr_t MOTION_ADDR  = 7'h02;
    localparam msp_addr_t DELTA_X_ADDR = 7'h03;
    localparam msp_addr_t DELTA_Y_ADDR = 7'h04;
    localparam msp_addr_t BURST_ADDR   = 7'h42;
    localparam logic [2:0] BURST_LAST  = 3'h7;

    // ==========================================================
    // States
    typedef enum logic [4:0] {
        D_IDLE  = 5'h01,
        D_ADDR  = 5'h02,
        D_WDATA = 5'h04,
        D_RDATA = 5'h08,
        D_LOCK  = 5'h10
    } msp_dev_state_e;

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_GAP   = 5'h02,
        H_SETUP = 5'h04,
        H_SHIFT = 5'h08,
        H_RAD   = 5'h10
    } msp_host_state_e;
endpackage : msp_pkg

// [test/msp_checker.sv]
// Assertions on the pins that join the host end to the sensor end.
// Assumes the host's default divider of 4 cycles per half period.
`timescale 1ns/100ps
module msp_checker (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic cs_n,
    input  wire logic miso_oe_n,
    input  wire logic miso_line
);
    localparam int RAD = 40;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    // ==========================================================
    // Length of the current high phase, saturating
    always_comb begin
        next_hi_cnt = (sys_rst_i || !sclk) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
    end
    always_ff @(posedge clk_i) begin
        hi_cnt <= next_hi_cnt;
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_SCLK_IDLE: assert property (cs_n |-> sclk)
        else $error("serial clock low while deselected");
    AST_CS_SETUP: assert property ($fell(cs_n) |-> sclk[*2])
        else $error("clock fell too soon after select");
    AST_HALF_HIGH: assert property ($rose(sclk) |-> sclk[*4])
        else $error("clock high phase too short");
    AST_MOSI_HOLD: assert property (!cs_n && $rose(sclk) |=> $stable(mosi)[*3])
        else $error("host data moved after a rising edge");
    AST_MISO_HOLD: assert property (!miso_oe_n && $rose(sclk) |-> ##2 $stable(miso_line)[*2])
        else $error("device data moved while clock high");
    AST_CS_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] miso_oe_n)
        else $error("device data pin not released");
    AST_OE_IDLE: assert property (cs_n[*6] |-> miso_oe_n && miso_line)
        else $error("device drives while deselected");
    AST_RAD: assert property ($fell(sclk) && !miso_oe_n |-> hi_cnt == 8'h04 || hi_cnt >= RAD)
        else $error("read data clocked before address-to-data delay");
endmodule : msp_checker

// [test/testbench.sv]
// Self-checking bench: host and sensor ends joined by one interface,
// plus a second sensor end driven by hand for deselect and abort cases.
// Assumes a 10 MHz clock and the host's default clock divider.
`timescale 1ns/100ps
module testbench;
    import msp_pkg::*;
    logic       clk_i, sys_rst_i, ev, cmd_valid, cmd_ready, cmd_write, extra_n;
    logic       rsp_valid, motion, rd_req, wr_valid, wr_valid_b;
    logic [2:0] extra;
    msp_addr_t  cmd_addr, rd_addr, wr_addr, wr_addr_b;
    msp_byte_t  cmd_data, rsp_data, rd_data, wr_data, wr_data_b;
    logic [15:0] mosi_sh, miso_sh, wq[$], bq[$];
    msp_byte_t  rq[$];
    int         n_mismatch, checks_done, k;
    msp_if mi();
    msp_if bi();
    msp_host u_msp_host (.clk_i, .sys_rst_i, .ce_i(1'b1), .bus(mi.host),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_extra_i(extra),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .motion_o(motion));
    msp_device u_msp_device (.clk_i, .sys_rst_i, .ce_i(1'b1), .bus(mi.dev),
        .motion_event_i(ev), .rd_data_i(rd_data), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
        .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    msp_device u_msp_device_b (.clk_i, .sys_rst_i, .ce_i(1'b1), .bus(bi.dev),
        .motion_event_i(1'b0), .rd_data_i(8'h00), .rd_req_o(), .rd_addr_o(),
        .wr_valid_o(wr_valid_b), .wr_addr_o(wr_addr_b), .wr_data_o(wr_data_b));
    msp_checker u_msp_checker (.clk_i, .sys_rst_i, .sclk(mi.sclk), .mosi(mi.mosi),
        .cs_n(mi.cs_n), .miso_oe_n(mi.miso_oe_n), .miso_line(mi.miso_line));
    // ==========================================================
    // Clock, register content and monitors
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (rd_req) rd_data <= 8'hA0 ^ {1'b0, rd_addr};
        if (wr_valid) wq.push_back({1'b0, wr_addr, wr_data});
        if (wr_valid_b) bq.push_back({1'b0, wr_addr_b, wr_data_b});
        if (rsp_valid) rq.push_back(rsp_data);
    end
    always @(posedge mi.sclk) begin
        if (!mi.cs_n) begin
            mosi_sh <= {mosi_sh[14:0], mi.mosi};
            miso_sh <= {miso_sh[14:0], mi.miso_line};
        end
    end
    // ==========================================================
    // Tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task wait_rdy;
        int i;
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge clk_i);
        if (i == 3000) begin
            n_mismatch++;
            end_sim();
        end
    endtask : wait_rdy
    // One host command, returns once the host is idle again
    task cmd(input logic w, input msp_addr_t a, input msp_byte_t d, input logic [2:0] x);
        wait_rdy();
        cmd_valid = 1'b1; cmd_write = w; cmd_addr = a; cmd_data = d; extra = x;
        @(negedge clk_i);
        cmd_valid = 1'b0;
        @(negedge clk_i);
        wait_rdy();
        // Last response byte is queued on the edge after ready returns
        @(negedge clk_i);
    endtask : cmd
    // Hand-driven frame bits on the second port, 800 ns per bit
    task bb(input logic [15:0] v, input int n);
        int i;
        for (i = n - 1; i >= 0; i--) begin
            bi.sclk = 1'b0; bi.mosi = v[i];
            repeat (4) @(negedge clk_i);
            bi.sclk = 1'b1;
            repeat (4) @(negedge clk_i);
        end
    endtask : bb
    task pulse_event;
        @(negedge clk_i) ev = 1'b1;
        @(negedge clk_i) ev = 1'b0;
        repeat (6) @(negedge clk_i);
    endtask : pulse_event
    // ==========================================================
    // Sequence
    initial begin
        n_mismatch = 0; checks_done = 0; sys_rst_i = 1'b1; ev = 1'b0;
        cmd_valid = 1'b0; cmd_write = 1'b0; cmd_addr = 7'h00; cmd_data = 8'h00; extra = 3'h0;
        bi.cs_n = 1'b1; bi.sclk = 1'b1; bi.mosi = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        cmd(1'b1, 7'h15, 8'hC3, 3'h0);
        cmd(1'b1, 7'h16, 8'h3C, 3'h0);
        chk(mosi_sh, 16'h963C);
        chk(wq.pop_front(), 16'h15C3);
        chk(wq.pop_front(), 16'h163C);
        cmd(1'b0, 7'h11, 8'h00, 3'h0);
        chk({8'h00, rq.pop_front()}, 16'h00B1);
        chk({mosi_sh[15:8], miso_sh[7:0]}, 16'h11B1);
        cmd(1'b0, BURST_ADDR, 8'h00, 3'h7);
        for (k = 0; k < 8; k++) chk({8'h00, rq.pop_front()}, {8'h00, 8'hA0 ^ (8'h02 + k[7:0])});
        cmd(1'b0, DELTA_X_ADDR, 8'h00, 3'h0);
        chk({8'h00, rq.pop_front()}, 16'h00A3);
        pulse_event();
        chk({14'h0000, mi.motion_n, motion}, 16'h0001);
        cmd(1'b0, DELTA_X_ADDR, 8'h00, 3'h0);
        repeat (6) @(negedge clk_i);
        chk({14'h0000, mi.motion_n, motion}, 16'h0001);
        cmd(1'b0, DELTA_Y_ADDR, 8'h00, 3'h0);
        repeat (6) @(negedge clk_i);
        chk({14'h0000, mi.motion_n, motion}, 16'h0002);
        pulse_event();
        cmd(1'b1, MOTION_ADDR, 8'h00, 3'h0);
        repeat (6) @(negedge clk_i);
        chk({14'h0000, mi.motion_n, motion}, 16'h0002);
        chk(16'(rq.size() + wq.size()), 16'h0003);
        bb(16'h9155, 16);
        chk({14'h0000, bi.miso_oe_n, bi.miso_line}, 16'h0003);
        bi.cs_n = 1'b0;
        repeat (4) @(negedge clk_i);
        bb(16'h001F, 5);
        bi.cs_n = 1'b1;
        repeat (300) @(negedge clk_i);
        bi.cs_n = 1'b0;
        repeat (4) @(negedge clk_i);
        bb(16'h91A5, 16);
        repeat (8) @(negedge clk_i);
        bi.cs_n = 1'b1;
        repeat (8) @(negedge clk_i);
        chk(16'(bq.size()), 16'h0001);
        chk(bq.pop_front(), 16'h11A5);
        end_sim();
    end
endmodule : testbench
